// file: burst_wrap_dpd_top.sv
// =====================================================
//
// Decided for this implementation: the register offsets and strobed register access.

`timescale 1ns/100ps
`default_nettype none

`include "bw_defs.svh"

module burst_wrap_dpd_top (
   input wire logic ref_clk_i, // 10 MHz system clock
   input wire logic rst_n_i, // synchronous reset, active low
   input wire logic por_n_i, // power-on reset pin, active low
   input wire logic hw_rst_n_i, // hardware reset pin, active low
   input wire logic cs_n_i, // chip select pin, active low
   input wire logic [3:0] reg_addr_i, // register address
   input wire logic [7:0] reg_wdata_i, // register write data
   input wire logic reg_wr_i, // register write strobe
   input wire logic reg_rd_i, // register read strobe
   input wire burst_wrap_pkg::rd_req_s rd_req_i, // read start/advance/stop
   output logic [7:0] reg_rdata_o, // read data, cycle after strobe
   output logic [31:0] rd_addr_o, // current read byte address
   output logic rd_active_o, // read in progress
   output logic deep_sleep_o, // deep sleep state
   output logic standby_o // standby state
);

   // =====================================================
   // pin synchronisers
   logic por_s1;
   logic por_s2;
   logic hw_s1;
   logic hw_s2;
   logic cs_s1;
   logic cs_s2;
   logic cs_s3;

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         por_s1 <= 1'b0;
         por_s2 <= 1'b0;
      end else begin
         por_s1 <= por_n_i;
         por_s2 <= por_s1;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         hw_s1 <= 1'b1;
         hw_s2 <= 1'b1;
      end else begin
         hw_s1 <= hw_rst_n_i;
         hw_s2 <= hw_s1;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         cs_s1 <= 1'b1;
         cs_s2 <= 1'b1;
         cs_s3 <= 1'b1;
      end else begin
         cs_s1 <= cs_n_i;
         cs_s2 <= cs_s1;
         cs_s3 <= cs_s2;
      end
   end

   logic hw_rst;
   logic cs_rise;

   assign hw_rst = !hw_s2;
   // pulse complete: chip select returns high after having been low
   assign cs_rise = cs_s2 && !cs_s3;

   // =====================================================
   // configuration registers
   logic [7:0] config_four_nonvolatile;
   logic [7:0] config_four_volatile;
   burst_wrap_pkg::power_state_e pwr_state;
   logic reload;

   // volatile copy is reloaded while power-on or hardware reset is active
   assign reload = (pwr_state == burst_wrap_pkg::PWR_POR) || hw_rst;

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         config_four_nonvolatile <= `BW_CFG_RESET;
      end else if (reg_wr_i && reg_addr_i == `BW_OFS_NONVOL) begin
         config_four_nonvolatile <= reg_wdata_i;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         config_four_volatile <= `BW_CFG_RESET;
      end else if (reload) begin
         config_four_volatile <= config_four_nonvolatile;
      end else if (reg_wr_i && reg_addr_i == `BW_OFS_VOL) begin
         config_four_volatile <= (reg_wdata_i & `BW_VOL_WMASK) |
                                 (config_four_volatile & ~`BW_VOL_WMASK);
      end
   end

   burst_wrap_pkg::wrap_cfg_s wrap_cfg;

   always_comb begin
      wrap_cfg.en = config_four_volatile[`BW_BIT_WRAP_EN];
      wrap_cfg.len = config_four_volatile[`BW_LEN_HI:`BW_LEN_LO];
   end

   // =====================================================
   // power state
   power_mode_ctl u_power (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .por_done_i(por_s2),
      .hw_rst_i(hw_rst),
      .cs_wake_i(cs_rise),
      .sleep_sel_i(config_four_nonvolatile[`BW_BIT_SLEEP_SEL]),
      .state_o(pwr_state)
   );

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         deep_sleep_o <= 1'b0;
         standby_o <= 1'b0;
      end else begin
         deep_sleep_o <= (pwr_state == burst_wrap_pkg::PWR_SLEEP);
         standby_o <= (pwr_state == burst_wrap_pkg::PWR_STANDBY);
      end
   end

   // =====================================================
   // read address sequencing
   logic rd_allow;

   // reads only in standby and outside hardware reset
   assign rd_allow = (pwr_state == burst_wrap_pkg::PWR_STANDBY) && !hw_rst;

   wrap_addr_gen u_addr (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .allow_i(rd_allow),
      .req_i(rd_req_i),
      .cfg_i(wrap_cfg),
      .addr_o(rd_addr_o),
      .active_o(rd_active_o)
   );

   // =====================================================
   // register read port
   logic [7:0] status;

   always_comb begin
      status = '0;
      status[`BW_ST_SLEEP] = (pwr_state == burst_wrap_pkg::PWR_SLEEP);
      status[`BW_ST_READ] = rd_active_o;
      status[`BW_ST_POR] = (pwr_state == burst_wrap_pkg::PWR_POR);
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= '0;
      end else if (reg_rd_i) begin
         unique case (reg_addr_i)
            `BW_OFS_NONVOL: reg_rdata_o <= config_four_nonvolatile;
            `BW_OFS_VOL: reg_rdata_o <= config_four_volatile;
            `BW_OFS_STATUS: reg_rdata_o <= status;
            default: reg_rdata_o <= '0;
         endcase
      end else begin
         reg_rdata_o <= '0;
      end
   end

   // =====================================================
   // checks
   logic rd_go;
   logic rd_adv;
   burst_wrap_pkg::wrap_cfg_s chk_cfg;
   logic [31:0] chk_mask;

   assign rd_go = rd_allow && rd_req_i.start;
   assign rd_adv = rd_allow && rd_active_o && rd_req_i.next && !rd_req_i.stop
                   && !rd_req_i.start;

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         chk_cfg <= '0;
      end else if (rd_go) begin
         chk_cfg <= wrap_cfg;
      end
   end

   assign chk_mask = burst_wrap_pkg::wrap_mask(chk_cfg.len);

   default clocking cb @(posedge ref_clk_i);
   endclocking

   default disable iff (!rst_n_i);

   por_standby_a: assert property (
      pwr_state == burst_wrap_pkg::PWR_POR && por_s2
      && !config_four_nonvolatile[`BW_BIT_SLEEP_SEL]
      |=> pwr_state == burst_wrap_pkg::PWR_STANDBY ##1 standby_o && !deep_sleep_o)
      else $error("standby not entered after power-on");

   por_sleep_a: assert property (
      pwr_state == burst_wrap_pkg::PWR_POR && por_s2
      && config_four_nonvolatile[`BW_BIT_SLEEP_SEL]
      |=> pwr_state == burst_wrap_pkg::PWR_SLEEP ##1 deep_sleep_o && !standby_o)
      else $error("deep sleep not entered after power-on");

   sleep_wake_a: assert property (
      pwr_state == burst_wrap_pkg::PWR_SLEEP && (cs_rise || hw_rst)
      |=> pwr_state == burst_wrap_pkg::PWR_STANDBY)
      else $error("deep sleep not left on wake event");

   sleep_hold_a: assert property (
      pwr_state == burst_wrap_pkg::PWR_SLEEP && !cs_rise && !hw_rst
      |=> pwr_state == burst_wrap_pkg::PWR_SLEEP)
      else $error("deep sleep left without wake event");

   first_byte_a: assert property (
      rd_go |=> rd_addr_o == $past(rd_req_i.addr) && rd_active_o)
      else $error("first read byte is not the start address");

   wrap_group_a: assert property (
      rd_adv && chk_cfg.en
      |=> (rd_addr_o & ~chk_mask) == ($past(rd_addr_o) & ~chk_mask))
      else $error("wrapped read left its aligned group");

   wrap_back_a: assert property (
      rd_adv && chk_cfg.en && (rd_addr_o & chk_mask) == chk_mask
      |=> (rd_addr_o & chk_mask) == '0)
      else $error("group end did not wrap to offset zero");

   len_eight_a: assert property (
      rd_adv && chk_cfg.en && chk_cfg.len == `BW_LEN_8
      && (rd_addr_o & `BW_MASK_8) == `BW_MASK_8
      |=> rd_addr_o == ($past(rd_addr_o) & ~`BW_MASK_8))
      else $error("8-byte wrap did not return to offset 00");

   len_long_a: assert property (
      rd_adv && chk_cfg.en && chk_cfg.len[1] && (rd_addr_o & chk_mask) == chk_mask
      ##1 rd_adv |=> (rd_addr_o & chk_mask) == `BW_ADDR_ONE)
      else $error("long wrap did not keep cycling");

   len_code_a: assert property (
      rd_go |=> burst_wrap_pkg::wrap_mask(chk_cfg.len) ==
         ((`BW_MASK_8 << chk_cfg.len) | `BW_MASK_8))
      else $error("wrap length code maps to wrong size");

   linear_a: assert property (
      rd_adv && !chk_cfg.en |=> rd_addr_o == $past(rd_addr_o) + `BW_ADDR_ONE)
      else $error("sequential read did not increment");

   addr_hold_a: assert property (
      !rd_go && !rd_adv
      |=> rd_addr_o == $past(rd_addr_o))
      else $error("read address moved without a request");

   wrap_low_a: assert property (
      rd_adv && chk_cfg.en
      |=> (rd_addr_o & chk_mask) == (($past(rd_addr_o) + `BW_ADDR_ONE) & chk_mask))
      else $error("wrapped low bits did not step by one");

   stop_end_a: assert property (
      rd_req_i.stop && !rd_req_i.start
      |=> !rd_active_o)
      else $error("read still active after stop");

   refuse_read_a: assert property (
      !rd_allow
      |=> !rd_active_o)
      else $error("read active outside standby");

   cfg_latch_a: assert property (
      rd_go |=> u_addr.cfg_q.en == $past(config_four_volatile[`BW_BIT_WRAP_EN])
      && u_addr.cfg_q.len == $past(config_four_volatile[`BW_LEN_HI:`BW_LEN_LO]))
      else $error("wrap settings not taken at read start");

   por_wait_a: assert property (
      pwr_state == burst_wrap_pkg::PWR_POR && !por_s2
      |=> pwr_state == burst_wrap_pkg::PWR_POR)
      else $error("power-on state left before reset finished");

   standby_keep_a: assert property (
      pwr_state == burst_wrap_pkg::PWR_STANDBY
      |=> pwr_state == burst_wrap_pkg::PWR_STANDBY)
      else $error("standby left without reset");

   state_excl_a: assert property (
      standby_o
      |-> !deep_sleep_o)
      else $error("standby and deep sleep shown together");

   reload_copy_a: assert property (
      reload
      |=> config_four_volatile == $past(config_four_nonvolatile))
      else $error("volatile copy not reloaded during reset");

   sel_readonly_a: assert property (
      reg_wr_i && reg_addr_i == `BW_OFS_VOL && !reload
      |=> config_four_volatile[`BW_BIT_SLEEP_SEL] ==
         $past(config_four_volatile[`BW_BIT_SLEEP_SEL]))
      else $error("volatile sleep select bit was written");

   status_sleep_a: assert property (
      reg_rd_i && reg_addr_i == `BW_OFS_STATUS
      |=> reg_rdata_o[`BW_ST_SLEEP] == $past(pwr_state == burst_wrap_pkg::PWR_SLEEP))
      else $error("status does not show deep sleep");

   sleep_entry_c: cover property (
      pwr_state == burst_wrap_pkg::PWR_POR ##1 pwr_state == burst_wrap_pkg::PWR_SLEEP);

   cs_wake_c: cover property (
      pwr_state == burst_wrap_pkg::PWR_SLEEP && cs_rise
      ##1 pwr_state == burst_wrap_pkg::PWR_STANDBY);

   wrap_64_c: cover property (
      rd_adv && chk_cfg.en && chk_cfg.len == `BW_LEN_64
      && (rd_addr_o & `BW_MASK_64) == `BW_MASK_64);

   linear_cross_c: cover property (
      rd_adv && !chk_cfg.en && (rd_addr_o & `BW_MASK_16) == `BW_MASK_16);

   hw_wake_c: cover property (
      pwr_state == burst_wrap_pkg::PWR_SLEEP && hw_rst
      ##1 pwr_state == burst_wrap_pkg::PWR_STANDBY);

endmodule

`default_nettype wire

// file: bw_defs.svh
`ifndef BW_DEFS_SVH
`define BW_DEFS_SVH

// register offsets on the plain register port
`define BW_OFS_NONVOL 4'h0
`define BW_OFS_VOL 4'h1
`define BW_OFS_STATUS 4'h2

// field positions inside the fourth configuration register
`define BW_BIT_WRAP_EN 4
`define BW_BIT_SLEEP_SEL 2
`define BW_LEN_HI 1
`define BW_LEN_LO 0

// status register bits
`define BW_ST_SLEEP 0
`define BW_ST_READ 1
`define BW_ST_POR 2

// factory default: impedance 101, wrap off, ecc 1, standby after power-on, 8 bytes
`define BW_CFG_RESET 8'hA8
// volatile copy: the power-on sleep select bit is read only
`define BW_VOL_WMASK 8'hFB

// wrap length codes and group masks
`define BW_LEN_8 2'h0
`define BW_LEN_16 2'h1
`define BW_LEN_32 2'h2
`define BW_LEN_64 2'h3
`define BW_MASK_8 32'h0000_0007
`define BW_MASK_16 32'h0000_000F
`define BW_MASK_32 32'h0000_001F
`define BW_MASK_64 32'h0000_003F
`define BW_ADDR_ONE 32'h0000_0001

`endif

// file: burst_wrap_pkg.sv
`include "bw_defs.svh"

package burst_wrap_pkg;

   typedef enum logic [1:0] {PWR_POR, PWR_STANDBY, PWR_SLEEP} power_state_e;

   typedef struct packed {
      logic en;
      logic [1:0] len;
   } wrap_cfg_s;

   typedef struct packed {
      logic start;
      logic next;
      logic stop;
      logic [31:0] addr;
   } rd_req_s;

   // low-order bits that move inside one wrap group
   function automatic logic [31:0] wrap_mask(input logic [1:0] len);
      logic [31:0] m;
      m = `BW_MASK_8;
      unique case (len)
         `BW_LEN_8: m = `BW_MASK_8;
         `BW_LEN_16: m = `BW_MASK_16;
         `BW_LEN_32: m = `BW_MASK_32;
         `BW_LEN_64: m = `BW_MASK_64;
      endcase
      return m;
   endfunction

   // next byte address: linear, or modulo the group with upper bits frozen
   function automatic logic [31:0] next_read_addr(input logic [31:0] a,
                                                  input wrap_cfg_s cfg);
      logic [31:0] m;
      logic [31:0] inc;
      m = wrap_mask(cfg.len);
      inc = a + `BW_ADDR_ONE;
      if (cfg.en) begin
         return (a & ~m) | (inc & m);
      end
      return inc;
   endfunction

endpackage

// file: power_mode_ctl.sv
`timescale 1ns/100ps
`default_nettype none

module power_mode_ctl (
   input wire logic ref_clk_i, // system clock
   input wire logic rst_n_i, // synchronous reset, active low
   input wire logic por_done_i, // power-on reset finished (synchronised)
   input wire logic hw_rst_i, // hardware reset pin asserted (synchronised)
   input wire logic cs_wake_i, // one-cycle pulse: chip select pulse completed
   input wire logic sleep_sel_i, // sleep after power-on selection
   output burst_wrap_pkg::power_state_e state_o // current power state
);

   // =====================================================
   // power state
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         state_o <= burst_wrap_pkg::PWR_POR;
      end else begin
         unique case (state_o)
            burst_wrap_pkg::PWR_POR: begin
               if (por_done_i) begin
                  state_o <= sleep_sel_i ? burst_wrap_pkg::PWR_SLEEP
                                         : burst_wrap_pkg::PWR_STANDBY;
               end
            end
            burst_wrap_pkg::PWR_STANDBY: begin
               state_o <= burst_wrap_pkg::PWR_STANDBY;
            end
            burst_wrap_pkg::PWR_SLEEP: begin
               if (hw_rst_i || cs_wake_i) begin
                  state_o <= burst_wrap_pkg::PWR_STANDBY;
               end
            end
            default: begin
               state_o <= burst_wrap_pkg::PWR_POR;
            end
         endcase
      end
   end

endmodule

`default_nettype wire

// file: wrap_addr_gen.sv
`timescale 1ns/100ps
`default_nettype none

module wrap_addr_gen (
   input wire logic ref_clk_i, // system clock
   input wire logic rst_n_i, // synchronous reset, active low
   input wire logic allow_i, // reads permitted (standby, not in reset)
   input wire burst_wrap_pkg::rd_req_s req_i, // read start/advance/stop
   input wire burst_wrap_pkg::wrap_cfg_s cfg_i, // wrap settings from register
   output logic [31:0] addr_o, // current byte address
   output logic active_o // read in progress
);

   burst_wrap_pkg::wrap_cfg_s cfg_q;

   // =====================================================
   // read sequencing
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         active_o <= 1'b0;
      end else if (allow_i && req_i.start) begin
         active_o <= 1'b1;
      end else if (!allow_i || req_i.stop) begin
         active_o <= 1'b0;
      end
   end

   // settings are caught at read start so a mid-read write cannot split a group
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         cfg_q <= '0;
      end else if (allow_i && req_i.start) begin
         cfg_q <= cfg_i;
      end
   end

   // =====================================================
   // address counter
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         addr_o <= '0;
      end else if (allow_i && req_i.start) begin
         addr_o <= req_i.addr;
      end else if (allow_i && active_o && req_i.next && !req_i.stop) begin
         addr_o <= burst_wrap_pkg::next_read_addr(addr_o, cfg_q);
      end
   end

endmodule

`default_nettype wire

// file: host_model.sv
`timescale 1ns/100ps
`default_nettype none

// =====================================================
// host controller: chip select and read stream requests
module host_model (
   input wire logic ref_clk_i, // system clock
   input wire logic [31:0] rd_addr_i, // device read address
   input wire logic rd_active_i, // device read in progress
   output burst_wrap_pkg::rd_req_s req_o, // read requests
   output logic cs_n_o // chip select, active low
);
   logic [31:0] seq [0:71];
   logic act [0:71];

   initial begin
      req_o = '0;
      cs_n_o = 1'b1;
   end

   // =====================================================
   // burst: start, n-1 advances, stop; one address logged per cycle
   // address bits outside start carry a changing pattern
   task automatic burst(input logic [31:0] a, input int n);
      @(posedge ref_clk_i) req_o <= '{1'b1, 1'b0, 1'b0, a};
      @(posedge ref_clk_i) req_o <= '{1'b0, 1'b1, 1'b0, ~a};
      #1 seq[0] = rd_addr_i;
      act[0] = rd_active_i;
      for (int i = 1; i < n; i++) begin
         @(posedge ref_clk_i);
         if (i == n - 1) begin
            req_o <= '{1'b0, 1'b0, 1'b1, a};
         end
         #1 seq[i] = rd_addr_i;
         act[i] = rd_active_i;
      end
      @(posedge ref_clk_i) req_o <= '{1'b0, 1'b0, 1'b0, ~a};
   endtask

   // =====================================================
   // wake pulse on chip select
   task automatic cs_pulse();
      @(posedge ref_clk_i) cs_n_o <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      cs_n_o <= 1'b1;
   endtask
endmodule

`default_nettype wire

// file: tb_top.sv
`timescale 1ns/100ps
`default_nettype none

`include "bw_defs.svh"

module tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic por_n = 1'b1;
   logic hw_rst_n = 1'b1;
   logic cs_n;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   burst_wrap_pkg::rd_req_s rd_req;
   logic [7:0] reg_rdata;
   logic [31:0] rd_addr;
   logic rd_active;
   logic deep_sleep;
   logic standby;
   logic [7:0] d;
   logic [31:0] a;
   logic [31:0] m;
   logic [7:0] offs [0:3] = '{8'h07, 8'h0C, 8'h1E, 8'h2E};
   int n;
   int n_fail = 0;
   int checks = 0;
   int cyc = 0;

   always #50 clk = ~clk;

   burst_wrap_dpd_top DUT (
      .ref_clk_i(clk), .rst_n_i(rst_n), .por_n_i(por_n), .hw_rst_n_i(hw_rst_n),
      .cs_n_i(cs_n), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
      .reg_rd_i(reg_rd), .rd_req_i(rd_req), .reg_rdata_o(reg_rdata), .rd_addr_o(rd_addr),
      .rd_active_o(rd_active), .deep_sleep_o(deep_sleep), .standby_o(standby)
   );

   host_model host (
      .ref_clk_i(clk), .rd_addr_i(rd_addr), .rd_active_i(rd_active), .req_o(rd_req),
      .cs_n_o(cs_n)
   );

   // =====================================================
   // tasks
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr_reg(input logic [3:0] ad, input logic [7:0] v);
      @(posedge clk) begin
         reg_addr <= ad;
         reg_wdata <= v;
         reg_wr <= 1'b1;
      end
      @(posedge clk) reg_wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [3:0] ad, output logic [7:0] v);
      @(posedge clk) begin
         reg_addr <= ad;
         reg_rd <= 1'b1;
      end
      @(posedge clk) reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask

   // power-on with sleep select stored while held in power-on reset
   task automatic sleep_boot();
      @(posedge clk) begin
         por_n <= 1'b0;
         rst_n <= 1'b0;
      end
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      wr_reg(`BW_OFS_NONVOL, 8'hAC);
      @(posedge clk) por_n <= 1'b1;
      repeat (6) @(posedge clk);
      #1 chk(32'(deep_sleep), 32'h1);
      chk(32'(standby), 32'h0);
      rd_reg(`BW_OFS_STATUS, d);
      chk(32'(d[`BW_ST_SLEEP]), 32'h1);
   endtask

   // =====================================================
   // watchdog
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_fail++;
         close_out();
      end
   end

   // =====================================================
   // main sequence
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rd_reg(`BW_OFS_NONVOL, d);
      chk(32'(d), 32'(`BW_CFG_RESET));
      rd_reg(`BW_OFS_VOL, d);
      chk(32'(d), 32'(`BW_CFG_RESET));
      wr_reg(4'h5, 8'hFF);
      rd_reg(4'h5, d);
      chk(32'(d), 32'h0);
      repeat (4) @(posedge clk);
      #1 chk(32'(standby), 32'h1);
      chk(32'(deep_sleep), 32'h0);
      $display("test reset done");

      for (int k = 0; k < 4; k++) begin
         a = 32'h1234_5600 | 32'(offs[k]);
         m = (32'h0000_0008 << k) - 32'h0000_0001;
         n = (8 << k) + 3;
         wr_reg(`BW_OFS_VOL, 8'h14 | 8'(k));
         rd_reg(`BW_OFS_VOL, d);
         chk(32'(d), 32'h10 | 32'(k));
         host.burst(a, n);
         chk(32'(host.act[0]), 32'h1);
         for (int i = 0; i < n; i++) begin
            chk(host.seq[i], (a & ~m) | ((a + 32'(i)) & m));
         end
      end
      $display("test wrap done");

      a = 32'h1234_56FC;
      wr_reg(`BW_OFS_VOL, 8'h03);
      host.burst(a, 24);
      for (int i = 0; i < 24; i++) begin
         chk(host.seq[i], a + 32'(i));
      end
      $display("test linear done");

      sleep_boot();
      host.burst(32'h0000_0040, 2);
      chk(32'(host.act[0]), 32'h0);
      chk(host.seq[1], 32'h0);
      host.cs_pulse();
      repeat (8) @(posedge clk);
      #1 chk(32'(standby), 32'h1);
      chk(32'(deep_sleep), 32'h0);
      $display("test chip select wake done");

      sleep_boot();
      @(posedge clk) hw_rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      hw_rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      #1 chk(32'(standby), 32'h1);
      chk(32'(deep_sleep), 32'h0);
      $display("test hardware reset wake done");
      close_out();
   end
endmodule

`default_nettype wire
